// file: core/stfs_filter.sv
// Hold-time filter: output rises once the input level has stood for CYCLES cycles.
`default_nettype none

module stfs_filter
    import stfs_pkg::*;
#(
    parameter int unsigned CYCLES = 1
) (
    input wire logic ref_clk,
    input wire logic clear_n,
    input wire logic level,
    output logic held
);

    logic [31:0] count_q;
    wire atEnd = (count_q >= 32'(CYCLES - 1));

    // Any drop of the level restarts the count, so glitches never accumulate.
    always_ff @(posedge ref_clk) begin
        if (!clear_n || !level) begin
            count_q <= '0;
            held <= 1'b0;
        end else if (!atEnd) begin
            count_q <= count_q + 32'h1;
        end else begin
            held <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// file: core/stfs_pkg.sv
// Shared types, timing counts and reset values of the supply and thermal fault supervisor.
`default_nettype none

package stfs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and timing. Each time is kept in its own unit; counts derive from it.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned RESET_FILTER_NS = 10000;
    localparam int unsigned RESET_FILTER_CYC = RESET_FILTER_NS / CLK_PERIOD_NS;
    localparam int unsigned RESET_DELAY_US = 2000;
    localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned SHORT_FILTER_US = 4000;
    localparam int unsigned SHORT_FILTER_CYC = SHORT_FILTER_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned OV_FILTER_NS = 7000;
    localparam int unsigned OV_FILTER_CYC = OV_FILTER_NS / CLK_PERIOD_NS;
    localparam int unsigned SEC_UV_FILTER_NS = 7000;
    localparam int unsigned SEC_UV_FILTER_CYC = SEC_UV_FILTER_NS / CLK_PERIOD_NS;
    // Minimum fail-safe hold after a device thermal shutdown; plain default value.
    localparam int unsigned DEVICE_OVERTEMP_SHUTDOWN_FLAG_MIN_US = 1000000;
    localparam int unsigned DEVICE_OVERTEMP_SHUTDOWN_FLAG_MIN_CYC = DEVICE_OVERTEMP_SHUTDOWN_FLAG_MIN_US * 1000 / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////////
    // Field codes and indices.
    localparam logic [1:0] RT_DISABLED = 2'h3;
    localparam logic [1:0] FAIL_NONE = 2'h0;
    localparam logic [1:0] FAIL_OVERTEMP = 2'h1;
    localparam logic BUS_WAKE_EN_RESET = 1'h0;
    localparam int unsigned NUM_LIN = 2;
    localparam int unsigned NUM_XCVR = 3;
    localparam int unsigned NUM_BLOCKS = 4;
    localparam int unsigned BLK_SEC = 0;
    localparam int unsigned BLK_XCVR0 = 1;

    // Operating mode as reported by the mode controller.
    typedef enum logic [2:0] {
        MODE_INIT = 3'h0,
        MODE_NORMAL = 3'h1,
        MODE_STOP = 3'h3,
        MODE_SLEEP = 3'h2,
        MODE_RESTART = 3'h6,
        MODE_FAILSAFE = 3'h7
    } stfs_mode_t;

    // Reset output sequencer.
    typedef enum logic [1:0] {
        RST_HOLD = 2'h0,
        RST_DELAY = 2'h1,
        RST_RUN = 2'h3
    } stfs_rst_t;

    // Comparator and wake inputs, all asynchronous to the clock.
    typedef struct packed {
        logic porOk;
        logic [2:0] mainBelowRt;
        logic mainOver;
        logic vsAboveTimeout;
        logic linSupplyLow;
        logic secBelowUv;
        logic [3:0] blockHot;
        logic buckPrewarn;
        logic buckHot;
        logic canWake;
        logic [1:0] linWake;
        logic wakePin;
    } stfs_sense_t;

    // Status flags; the same layout serves as the clear mask.
    typedef struct packed {
        logic por;
        logic linSupplyUv;
        logic mainUv;
        logic mainOv;
        logic mainShort;
        logic buckShort;
        logic secUv;
        logic blockTsd;
        logic secOt;
        logic tempPrewarn;
        logic deviceTsd;
        logic [2:0][1:0] xcvrFail;
    } stfs_flags_t;

    localparam stfs_flags_t FLAGS_POR = '{por: 1'b1, default: '0};

endpackage

`default_nettype wire

// file: core/stfs_supervisor.sv
// Supply, reset and thermal fault supervisor of the system basis chip.
//
// What this block does
// - Bus-wake watchdog start bit changes only in Normal.
// - Stop-mode bus wake restarts disabled watchdog, long window.
// - Stop-mode bus wake interrupts, pulls receive output low.
// - Power-on sets flag, loads all defaults.
// - Reset held until main output high plus delay.
// - Battery loss resets; restart in Init afterwards.
// - LIN supply low: flag and receive-only.
// - Main undervoltage: reset, restart, flag; threshold selectable.
// - Threshold select 11 disables main undervoltage.
// - No main undervoltage flag in Sleep, Fail-Safe, except from a sustained short.
// - Overvoltage detection only in Init, Normal, Stop.
// - Overvoltage flags always; optional reset, then Normal.
// - Sustained short: Fail-Safe, buck off, three flags.
// - Any wake reactivates after short-circuit shutdown.
// - Switcher status bits change no mode, no transceiver.
// - Filtered secondary undervoltage sets sticky warning flag.
// - First thermal level switches blocks off, sets flag.
// - Secondary overtemperature clears on-control, sets flag.
// - Transceiver overtemperature disables transmitter, field 01.
// - Buck prewarning sets flag while buck runs.
// - Device thermal shutdown only in PWM operation.
// - Device thermal shutdown holds Fail-Safe, minimum time.
`default_nettype none

module stfs_supervisor
    import stfs_pkg::*;
#(
    parameter int unsigned RESET_DELAY_CYCLES = RESET_DELAY_CYC,
    parameter int unsigned SHORT_FILTER_CYCLES = SHORT_FILTER_CYC,
    parameter int unsigned DEVICE_OVERTEMP_SHUTDOWN_FLAG_MIN_CYCLES = DEVICE_OVERTEMP_SHUTDOWN_FLAG_MIN_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire stfs_sense_t sense,
    input wire stfs_mode_t mode,
    input wire logic [1:0] resetThresholdSelect,
    input wire logic overvoltResetEnable,
    input wire logic busWakeEnWrite,
    input wire logic busWakeEnData,
    input wire logic watchdogOffInStop,
    input wire logic watchdogActive,
    input wire logic buckOn,
    input wire logic buckPwm,
    input wire logic secondaryRamping,
    input wire logic [3:0] blockOn,
    input wire stfs_flags_t flagClear,
    output stfs_flags_t flags,
    output logic busWakeWatchdogStartEnable,
    output logic resetOutputN,
    output logic initRequest,
    output logic restartRequest,
    output logic resumeNormal,
    output logic failsafeRequest,
    output logic failsafeOutputs,
    output logic defaultWakeEnable,
    output logic buckOff,
    output logic wakeReactivate,
    output logic wakeInterrupt,
    output logic watchdogLongWindowStart,
    output logic canReceiveLow,
    output logic [1:0] linReceiveLow,
    output logic [1:0] linReceiveOnly,
    output logic secondaryOnClear,
    output logic [2:0] txDisable
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers.

    // Modes in which the main regulator is expected to run and be watched.
    function automatic logic regulatorWatched(input stfs_mode_t m);
        return (m == MODE_INIT) || (m == MODE_NORMAL) || (m == MODE_STOP);
    endfunction

    // Sticky flag update. Set beats clear; a clear is ignored while the cause stays.
    function automatic logic stickyNext(input logic q, input logic set,
                                        input logic clr, input logic cause);
        return set | (q & ~(clr & ~cause));
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisation and core reset.

    stfs_sense_t sync;
    logic coreRst_n;

    // Comparator outputs cross into the clock domain before any logic reads them.
    stfs_sync #(
        .WIDTH($bits(stfs_sense_t))
    ) u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .asyncIn(sense),
        .syncOut(sync)
    );

    // Losing the battery supply resets every register of the block except the input synchroniser.
    assign coreRst_n = reset_n & sync.porOk;

    ////////////////////////////////////////////////////////////////////////////////
    // Main regulator threshold selection and filters.

    logic belowSel;
    logic uvLevel;
    logic uvFilt;
    logic ovFilt;
    logic ovActive;
    logic scLevel;
    logic scFilt;
    logic scTrip;
    logic secUvFilt;
    logic delayDone;
    logic tsd2Done;
    stfs_rst_t rst_q;
    stfs_rst_t rst_d;
    logic ovRstHold_q;
    logic scLatched_q;
    logic tsd2Hold_q;

    // Select code 11 masks the undervoltage comparator entirely.
    assign belowSel = (resetThresholdSelect == RT_DISABLED) ? 1'b0
                    : sync.mainBelowRt[resetThresholdSelect];
    // With the regulator off in Sleep or Fail-Safe, a low output is expected.
    assign uvLevel = belowSel & regulatorWatched(mode)
                   | belowSel & (mode == MODE_RESTART);
    assign ovActive = ovFilt & regulatorWatched(mode);
    assign scLevel = belowSel & sync.vsAboveTimeout & ~scLatched_q;
    assign scTrip = scFilt & ~scLatched_q;

    // All filter and delay times are counters on the system clock.
    stfs_filter #(.CYCLES(RESET_FILTER_CYC)) u_uvFilter (
        .ref_clk(ref_clk),
        .clear_n(coreRst_n),
        .level(uvLevel),
        .held(uvFilt)
    );

    stfs_filter #(.CYCLES(OV_FILTER_CYC)) u_ovFilter (
        .ref_clk(ref_clk),
        .clear_n(coreRst_n),
        .level(sync.mainOver),
        .held(ovFilt)
    );

    stfs_filter #(.CYCLES(SHORT_FILTER_CYCLES)) u_scFilter (
        .ref_clk(ref_clk),
        .clear_n(coreRst_n),
        .level(scLevel),
        .held(scFilt)
    );

    stfs_filter #(.CYCLES(SEC_UV_FILTER_CYC)) u_secUvFilter (
        .ref_clk(ref_clk),
        .clear_n(coreRst_n),
        .level(sync.secBelowUv),
        .held(secUvFilt)
    );

    stfs_filter #(.CYCLES(RESET_DELAY_CYCLES)) u_delayTimer (
        .ref_clk(ref_clk),
        .clear_n(coreRst_n),
        .level(rst_q == RST_DELAY),
        .held(delayDone)
    );

    stfs_filter #(.CYCLES(DEVICE_OVERTEMP_SHUTDOWN_FLAG_MIN_CYCLES)) u_tsd2Timer (
        .ref_clk(ref_clk),
        .clear_n(coreRst_n),
        .level(tsd2Hold_q),
        .held(tsd2Done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Reset output sequencer.

    // The output is released only after the main rail has stood above its
    // threshold for the whole delay; an undervoltage, an overvoltage reset or a short restarts the sequence.
    always_comb begin
        rst_d = rst_q;
        unique case (rst_q)
            RST_HOLD: begin
                if (!belowSel && !ovRstHold_q && !scLatched_q) begin
                    rst_d = RST_DELAY;
                end
            end
            RST_DELAY: begin
                if (belowSel || ovRstHold_q || scLatched_q) begin
                    rst_d = RST_HOLD;
                end else if (delayDone) begin
                    rst_d = RST_RUN;
                end
            end
            RST_RUN: begin
                if (uvFilt || ovRstHold_q || scLatched_q) begin
                    rst_d = RST_HOLD;
                end
            end
            default: begin
                rst_d = RST_HOLD;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!coreRst_n) begin
            rst_q <= RST_HOLD;
            resetOutputN <= 1'b0;
        end else begin
            rst_q <= rst_d;
            resetOutputN <= (rst_d == RST_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode requests. Only supply and thermal causes below steer the mode; the
    // switcher status bits are not inputs here, so they never change it.

    logic anyWake;
    logic busWake;
    logic [3:0] wake_q;
    logic [3:0] wakeEdge;
    logic tsd2Trip;

    assign wakeEdge = {sync.canWake, sync.linWake, sync.wakePin} & ~wake_q;
    assign busWake = wakeEdge[3] | wakeEdge[2] | wakeEdge[1];
    assign anyWake = |wakeEdge;
    // Device shutdown watches only the buck in PWM operation.
    assign tsd2Trip = sync.buckHot & buckOn & buckPwm & ~tsd2Hold_q;

    // Overvoltage reset is held until the rail falls back, whatever the mode.
    always_ff @(posedge ref_clk) begin
        if (!coreRst_n) begin
            ovRstHold_q <= 1'b0;
            resumeNormal <= 1'b0;
            restartRequest <= 1'b0;
        end else begin
            ovRstHold_q <= (ovActive & overvoltResetEnable) | (ovRstHold_q & ovFilt);
            resumeNormal <= ovRstHold_q & ~ovFilt;
            restartRequest <= uvFilt | ovRstHold_q;
        end
    end

    // Fail-Safe latches; a wake ends them, the thermal one only after its
    // minimum time and once the buck has cooled.
    always_ff @(posedge ref_clk) begin
        if (!coreRst_n) begin
            scLatched_q <= 1'b0;
            tsd2Hold_q <= 1'b0;
            wakeReactivate <= 1'b0;
            wake_q <= '0;
        end else begin
            wake_q <= {sync.canWake, sync.linWake, sync.wakePin};
            scLatched_q <= scTrip | (scLatched_q & ~anyWake);
            tsd2Hold_q <= tsd2Trip
                        | (tsd2Hold_q & ~(tsd2Done & anyWake & ~sync.buckHot));
            wakeReactivate <= anyWake & (scLatched_q | (tsd2Hold_q & tsd2Done));
        end
    end

    assign failsafeRequest = scLatched_q | tsd2Hold_q;
    assign failsafeOutputs = scLatched_q | tsd2Hold_q;
    assign defaultWakeEnable = tsd2Hold_q | scLatched_q;
    assign buckOff = scLatched_q;

    // Init request stands during the internal reset and one cycle after it.
    always_ff @(posedge ref_clk) begin
        if (!coreRst_n) begin
            initRequest <= 1'b1;
        end else begin
            initRequest <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus wake in Stop mode and the watchdog restart.

    logic stopBusWake;

    assign stopBusWake = (mode == MODE_STOP) & busWake;

    // The enable may be written only in Normal, and the block never clears it;
    // software must set it before Stop and must itself re-arm the watchdog off
    // sequence in Normal after a wake has restarted it.
    always_ff @(posedge ref_clk) begin
        if (!coreRst_n) begin
            busWakeWatchdogStartEnable <= BUS_WAKE_EN_RESET;
        end else if (busWakeEnWrite && mode == MODE_NORMAL) begin
            busWakeWatchdogStartEnable <= busWakeEnData;
        end
    end

    // Receive outputs stay low from the wake until the mode leaves Stop.
    always_ff @(posedge ref_clk) begin
        if (!coreRst_n) begin
            wakeInterrupt <= 1'b0;
            watchdogLongWindowStart <= 1'b0;
            canReceiveLow <= 1'b0;
            linReceiveLow <= '0;
        end else begin
            wakeInterrupt <= stopBusWake;
            watchdogLongWindowStart <= stopBusWake & busWakeWatchdogStartEnable
                                     & watchdogOffInStop;
            canReceiveLow <= (mode == MODE_STOP)
                           & (canReceiveLow | wakeEdge[3]);
            linReceiveLow <= {2{mode == MODE_STOP}}
                           & (linReceiveLow | wakeEdge[2:1]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Individual block thermal protection.

    logic secProtect;
    logic [3:0] blockTrip;
    logic [2:0][1:0] failNext;

    // Secondary regulator is guarded only in Normal, or Stop with watchdog.
    assign secProtect = (mode == MODE_NORMAL) | ((mode == MODE_STOP) & watchdogActive);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BLOCKS; gi++) begin : g_block
            if (gi == BLK_SEC) begin : g_sec
                assign blockTrip[gi] = sync.blockHot[gi] & blockOn[gi] & secProtect;
            end else begin : g_xcvr
                // Protection acts only on a block that is switched on.
                assign blockTrip[gi] = sync.blockHot[gi] & blockOn[gi];
            end
        end
        for (gi = 0; gi < NUM_XCVR; gi++) begin : g_fail
            // Field goes to 01 on a trip and returns to 00 only on a clear
            // given after the block has cooled.
            assign failNext[gi] = blockTrip[gi + BLK_XCVR0] ? FAIL_OVERTEMP
                : ((flagClear.xcvrFail[gi] != FAIL_NONE)
                   && !sync.blockHot[gi + BLK_XCVR0]) ? FAIL_NONE
                : flags.xcvrFail[gi];
        end
    endgenerate

    // Transmitters return on their own once cool; the transceiver mode stays.
    always_ff @(posedge ref_clk) begin
        if (!coreRst_n) begin
            txDisable <= '0;
            secondaryOnClear <= 1'b0;
            linReceiveOnly <= '0;
        end else begin
            txDisable <= blockTrip[3:1];
            secondaryOnClear <= blockTrip[BLK_SEC];
            linReceiveOnly <= {NUM_LIN{sync.linSupplyLow}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status flags.

    stfs_flags_t flagsNext;

    always_comb begin
        flagsNext = flags;
        flagsNext.por = flags.por & ~flagClear.por;
        flagsNext.linSupplyUv = stickyNext(flags.linSupplyUv, sync.linSupplyLow,
                                           flagClear.linSupplyUv, sync.linSupplyLow);
        flagsNext.mainUv = stickyNext(flags.mainUv, uvFilt | scTrip,
                                      flagClear.mainUv, belowSel);
        flagsNext.mainOv = stickyNext(flags.mainOv, ovActive,
                                      flagClear.mainOv, ovFilt);
        flagsNext.mainShort = stickyNext(flags.mainShort, scTrip,
                                         flagClear.mainShort, scLatched_q);
        flagsNext.buckShort = stickyNext(flags.buckShort, scTrip,
                                         flagClear.buckShort, scLatched_q);
        // Ramping of the secondary regulator masks the undervoltage warning.
        flagsNext.secUv = stickyNext(flags.secUv, secUvFilt & ~secondaryRamping,
                                     flagClear.secUv, sync.secBelowUv);
        flagsNext.blockTsd = stickyNext(flags.blockTsd, |blockTrip,
                                        flagClear.blockTsd, |sync.blockHot);
        flagsNext.secOt = stickyNext(flags.secOt, blockTrip[BLK_SEC],
                                     flagClear.secOt, sync.blockHot[BLK_SEC]);
        flagsNext.tempPrewarn = stickyNext(flags.tempPrewarn, sync.buckPrewarn & buckOn,
                                           flagClear.tempPrewarn, sync.buckPrewarn);
        // Device shutdown flag may be cleared only in Normal after cooling.
        flagsNext.deviceTsd = stickyNext(flags.deviceTsd, tsd2Trip, flagClear.deviceTsd,
                                         sync.buckHot | (mode != MODE_NORMAL));
        flagsNext.xcvrFail = failNext;
    end

    // Power-on loads the flags with the power-on flag already set.
    always_ff @(posedge ref_clk) begin
        if (!coreRst_n) begin
            flags <= FLAGS_POR;
        end else begin
            flags <= flagsNext;
        end
    end

endmodule

`default_nettype wire

// file: core/stfs_sync.sv
// Two-flop synchroniser for the asynchronous comparator and wake inputs.
`default_nettype none

module stfs_sync
    import stfs_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_q;

    // Only the second stage is visible outside; the first may be metastable.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule

`default_nettype wire

// file: verif/stfs_mcu_model.sv
// Behavioural controller that owns the operating mode seen by the supervisor.
`default_nettype none
module stfs_mcu_model
    import stfs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire stfs_mode_t modeSet,
    input wire logic modeLoad,
    input wire logic wakeInterrupt,
    output stfs_mode_t mode
);
    timeunit 1ns;
    timeprecision 1ns;
    // A Stop-mode bus wake is answered by a return to Normal.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) mode <= MODE_INIT;
        else if (wakeInterrupt && mode == MODE_STOP) mode <= MODE_NORMAL;
        else if (modeLoad) mode <= modeSet;
    end
endmodule
`default_nettype wire

// file: verif/stfs_sup_asserts.sv
// Port-level assertions for the supply and thermal fault supervisor.
`default_nettype none
module stfs_sup_asserts
    import stfs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire stfs_mode_t mode,
    input wire logic [1:0] resetThresholdSelect,
    input wire logic busWakeEnWrite,
    input wire stfs_flags_t flags,
    input wire logic busWakeWatchdogStartEnable,
    input wire logic resetOutputN,
    input wire logic failsafeRequest,
    input wire logic failsafeOutputs,
    input wire logic buckOff,
    input wire logic wakeInterrupt,
    input wire logic watchdogLongWindowStart,
    input wire logic [1:0] linReceiveOnly,
    input wire logic [2:0] txDisable
);
    timeunit 1ns;
    timeprecision 1ns;
    // One clock domain.
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////
    wake_write_a: assert property (
        busWakeEnWrite && mode != MODE_NORMAL |=> $stable(busWakeWatchdogStartEnable))
        else $error("enable changed");
    long_window_a: assert property (
        watchdogLongWindowStart |-> busWakeWatchdogStartEnable && $past(mode) == MODE_STOP)
        else $error("stray start");
    wake_pulse_a: assert property ($rose(wakeInterrupt) |=> !wakeInterrupt)
        else $error("long wake pulse");
    reset_hold_a: assert property (
        $rose(resetOutputN) |-> $past(resetOutputN, 8) == 1'b0)
        else $error("early release");
    uv_reset_a: assert property (
        $fell(resetOutputN) |-> ##[0:2] (flags.mainUv || flags.mainOv))
        else $error("reset, no flag");
    rt_off_a: assert property (
        $rose(flags.mainUv) |-> $past(resetThresholdSelect) != RT_DISABLED)
        else $error("uv flag while off");
    uv_mode_a: assert property (
        $rose(flags.mainUv) |-> !($past(mode) inside {MODE_SLEEP, MODE_FAILSAFE}))
        else $error("uv flag in wrong mode");
    short_off_a: assert property (
        buckOff |-> (failsafeRequest && failsafeOutputs) ##[0:1] flags.buckShort)
        else $error("buck off alone");
    lin_only_a: assert property (linReceiveOnly[0] |-> ##[0:2] flags.linSupplyUv)
        else $error("receive-only, no flag");
    tx_fail_a: assert property (
        $rose(txDisable[0]) |-> ##[0:2] flags.xcvrFail[0] == FAIL_OVERTEMP)
        else $error("tx off, no code");
    // Main scenarios.
    wake_c: cover property ($rose(wakeInterrupt));
    short_c: cover property ($rose(buckOff));
    uv_c: cover property ($fell(resetOutputN));
endmodule
bind stfs_supervisor stfs_sup_asserts i_stfs_sup_asserts (.*);
`default_nettype wire

// file: verif/tb_stfs_supervisor.sv
// Self-checking bench for the supply and thermal fault supervisor.
`default_nettype none
module tb_stfs_supervisor
    import stfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    stfs_sense_t sense = '{porOk: 1'b1, default: '0};
    stfs_mode_t modeSet = MODE_INIT;
    stfs_mode_t mode;
    stfs_flags_t flagClear = '0;
    stfs_flags_t flags;
    stfs_flags_t hotClr = '{blockTsd: 1'b1, xcvrFail: '1, default: '0};
    logic [1:0] rts = 2'h0;
    logic modeLoad = 1'b0;
    logic bwWr = 1'b0;
    logic bwData = 1'b0;
    logic wdOff = 1'b0, ovRst = 1'b0, wdAct = 1'b0, pwm = 1'b0, ramp = 1'b0;
    logic bwEn, rstN, buckOff, wakeIrq, longWin, canLow;
    logic [1:0] linRo;
    logic [2:0] txDis;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////
    // Short counts keep the run brief.
    stfs_supervisor #(.RESET_DELAY_CYCLES(20), .SHORT_FILTER_CYCLES(30), .DEVICE_OVERTEMP_SHUTDOWN_FLAG_MIN_CYCLES(50))
    i_stfs_supervisor (.ref_clk, .reset_n, .sense, .mode, .resetThresholdSelect(rts),
        .overvoltResetEnable(ovRst), .busWakeEnWrite(bwWr), .busWakeEnData(bwData),
        .watchdogOffInStop(wdOff), .watchdogActive(wdAct), .buckOn(1'b1), .buckPwm(pwm),
        .secondaryRamping(ramp), .blockOn(4'hf), .flagClear, .flags,
        .busWakeWatchdogStartEnable(bwEn),
        .resetOutputN(rstN), .initRequest(), .restartRequest(), .resumeNormal(),
        .failsafeRequest(), .failsafeOutputs(), .defaultWakeEnable(), .buckOff(buckOff),
        .wakeReactivate(), .wakeInterrupt(wakeIrq), .watchdogLongWindowStart(longWin),
        .canReceiveLow(canLow), .linReceiveLow(), .linReceiveOnly(linRo),
        .secondaryOnClear(), .txDisable(txDis));
    stfs_mcu_model i_stfs_mcu_model (.ref_clk, .reset_n, .modeSet, .modeLoad,
        .wakeInterrupt(wakeIrq), .mode);
    ////////////////////////////////////////////////////////////////////////
    // Clock and cycle ceiling.
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic waitHigh(ref logic sig, input int lim);
        for (int k = 0; k < lim && sig !== 1'b1; k++) step(1);
    endtask
    task automatic setMode(input stfs_mode_t m);
        modeSet <= m;
        modeLoad <= 1'b1;
        step(1);
        modeLoad <= 1'b0;
    endtask
    // One strobe per call.
    task automatic writeEn(input logic d);
        bwData <= d;
        bwWr <= 1'b1;
        step(1);
        bwWr <= 1'b0;
        step(2);
    endtask
    task automatic clearFlags(input stfs_flags_t m);
        flagClear <= m;
        step(1);
        flagClear <= '0;
        step(2);
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        step(5);
        reset_n <= 1'b1;
        step(2);
        chk("por flags", flags, 17'h10000);
        chk("ro held", rstN, 0);
        waitHigh(rstN, 100);
        chk("ro released", rstN, 1);
        writeEn(1'b1);
        chk("en in init", bwEn, 0);
        setMode(MODE_NORMAL);
        writeEn(1'b1);
        chk("en in normal", bwEn, 1);
        wdOff <= 1'b1;
        setMode(MODE_STOP);
        sense.canWake <= 1'b1;
        waitHigh(wakeIrq, 10);
        chk("wake irq", wakeIrq, 1);
        chk("long window", longWin, 1);
        chk("can low", canLow, 1);
        sense.canWake <= 1'b0;
        step(5);
        chk("can released", canLow, 0);
        sense.blockHot[1] <= 1'b1;
        step(8);
        chk("can tx off", txDis, 3'h1);
        chk("can fail", flags.xcvrFail[0], FAIL_OVERTEMP);
        chk("block flag", flags.blockTsd, 1);
        clearFlags(hotClr);
        chk("fail kept", flags.xcvrFail[0], FAIL_OVERTEMP);
        sense.blockHot[1] <= 1'b0;
        step(6);
        chk("can tx on", txDis, 3'h0);
        clearFlags(hotClr);
        chk("fail cleared", flags.xcvrFail[0], FAIL_NONE);
        sense.linSupplyLow <= 1'b1;
        step(6);
        chk("lin ro", linRo, 2'h3);
        chk("lin flag", flags.linSupplyUv, 1);
        sense.linSupplyLow <= 1'b0;
        rts <= RT_DISABLED;
        sense.mainBelowRt <= 3'h7;
        step(1100);
        chk("uv off flag", flags.mainUv, 0);
        chk("uv off ro", rstN, 1);
        rts <= 2'h0;
        step(1100);
        chk("uv flag", flags.mainUv, 1);
        chk("uv ro", rstN, 0);
        sense.vsAboveTimeout <= 1'b1;
        step(1100);
        chk("buck off", buckOff, 1);
        chk("short flag", flags.mainShort, 1);
        stop_test();
    end
endmodule
`default_nettype wire
